// ### rtl/dbs_pkg.sv
// constants and types for the ddr burst-of-four sram bus-cycle logic
// assumes clock edges of the sram pins arrive as synchronous one-cycle strobes
package dbs_pkg;
  localparam int DBS_ADDR_W = 18;
  localparam int DBS_DATA_W = 36;
  localparam int DBS_CLK_PERIOD_NS = 100;
  localparam logic [2:0] DBS_BURST_LEN = 3'h4;
  localparam logic [2:0] DBS_BEAT_LAST = 3'h3;
  localparam logic [2:0] DBS_CNT_ZERO = 3'h0;
  localparam logic [2:0] DBS_CNT_ONE = 3'h1;
  localparam int DBS_BUF_DEPTH = 2;

  typedef enum logic [1:0] {DBS_IDLE, DBS_WRITE, DBS_READ} dbs_mode_t;

  // rising-edge strobes of the input and output clock pairs
  typedef struct packed {
    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
  } dbs_edges_t;

  typedef struct packed {
    logic load_strobe_n;
    logic rw_sel;
    logic [DBS_ADDR_W-1:0] addr;
  } dbs_cmd_t;
endpackage

// ### rtl/dbs_fifo2.sv
// small valid/ready buffer between the sram array and the read launch stage
// assumes single clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module dbs_fifo2 #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dbs_fifo_state_t;

  dbs_fifo_state_t st_ff;
  dbs_fifo_state_t nxt_st;
  logic push;
  logic pop;

  assign in_ready = (st_ff.cnt != FULL_CNT);
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == LAST_PTR) ? '0 : st_ff.wp + PW'(1);
    end
    if (pop)
    begin
      nxt_st.rp = (st_ff.rp == LAST_PTR) ? '0 : st_ff.rp + PW'(1);
    end
    if (push && !pop)
    begin
      nxt_st.cnt = st_ff.cnt + (PW+1)'(1);
    end
    else if (pop && !push)
    begin
      nxt_st.cnt = st_ff.cnt - (PW+1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_fifo_no_overrun: assert property (st_ff.cnt == FULL_CNT |-> !push)
    else $error("buffer accepted a word while full");
  c_fifo_full: cover property (st_ff.cnt == FULL_CNT);
endmodule
`default_nettype wire

// ### rtl/dbs_bus_cycle.sv
// bus-cycle logic of a burst-of-four double-data-rate synchronous sram
// assumes every pin clock edge is presented as a core_clk-synchronous strobe
// Function
// [R01] load low, select low starts write burst
// [R02] load low, select high starts read burst
// [R03] controls sampled only on true input edge
// [R04] write words taken on both input edges
// [R05] output clocks high: launch on input edges
// [R06] first word uses external address
// [R07] data pins high impedance after power-up
// [R08] park stopped clocks complementary, advised only
// [R09] low two address bits wrap linearly
// [R10] burst ends after four words
// [R11] load high while idle does nothing
// [R12] stopped clock keeps all state; read prefetch still fills the buffer
`timescale 1ns/1ps
`default_nettype none
module dbs_bus_cycle (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire dbs_pkg::dbs_edges_t edges,
  input wire logic out_clks_high,
  input wire dbs_pkg::dbs_cmd_t cmd,
  input wire logic [dbs_pkg::DBS_DATA_W-1:0] dq_in,
  output logic [dbs_pkg::DBS_DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic echo_strobe_pos,
  output logic echo_strobe_neg,
  output logic busy
);
  import dbs_pkg::*;

  typedef struct packed {
    dbs_mode_t mode;
    logic [DBS_ADDR_W-1:0] base;
    logic [2:0] wbeat;
    logic [2:0] fetch;
    logic [2:0] launch;
    logic [DBS_DATA_W-1:0] dq;
    logic oe;
    logic echo_p;
    logic echo_n;
  } dbs_state_t;

  dbs_state_t st_ff;
  dbs_state_t nxt_st;
  logic [DBS_DATA_W-1:0] mem [0:(1<<DBS_ADDR_W)-1];

  logic launch_pos;
  logic launch_neg;
  logic cmd_take;
  logic wr_take;
  logic [DBS_ADDR_W-1:0] wr_addr;
  logic [DBS_ADDR_W-1:0] rd_addr;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [DBS_DATA_W-1:0] buf_out_data;

  function automatic logic [DBS_ADDR_W-1:0] burst_addr(
    input logic [DBS_ADDR_W-1:0] base,
    input logic [2:0] idx
  );
    burst_addr = {base[DBS_ADDR_W-1:2], 2'(base[1:0] + idx[1:0])}; // R06 R09
  endfunction

  // fall back to the input clocks when both output clocks sit high
  assign launch_pos = out_clks_high ? edges.k_rise : edges.c_rise; // R05
  assign launch_neg = out_clks_high ? edges.kn_rise : edges.cn_rise; // R05

  assign cmd_take = edges.k_rise && (st_ff.mode == DBS_IDLE) && !cmd.load_strobe_n; // R03 R11
  assign wr_take = (st_ff.mode == DBS_WRITE) &&
    (st_ff.wbeat[0] ? edges.kn_rise : edges.k_rise); // R04
  assign wr_addr = burst_addr(st_ff.base, st_ff.wbeat);
  assign rd_addr = burst_addr(st_ff.base, st_ff.fetch);

  assign buf_in_valid = (st_ff.mode == DBS_READ) && (st_ff.fetch != DBS_BURST_LEN);
  assign buf_out_ready = (st_ff.mode == DBS_READ) && (st_ff.launch != DBS_BURST_LEN) &&
    (st_ff.launch[0] ? launch_neg : launch_pos); // R02

  dbs_fifo2 #(
    .WIDTH(DBS_DATA_W),
    .DEPTH(DBS_BUF_DEPTH)
  ) u_rd_buf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(mem[rd_addr]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.echo_p = launch_pos;
    nxt_st.echo_n = launch_neg;
    case (st_ff.mode)
      DBS_IDLE:
      begin
        if (cmd_take)
        begin
          nxt_st.base = cmd.addr; // R06
          nxt_st.wbeat = DBS_CNT_ZERO;
          nxt_st.fetch = DBS_CNT_ZERO;
          nxt_st.launch = DBS_CNT_ZERO;
          nxt_st.mode = cmd.rw_sel ? DBS_READ : DBS_WRITE; // R01 R02
        end
      end
      DBS_WRITE:
      begin
        if (wr_take)
        begin
          nxt_st.wbeat = st_ff.wbeat + DBS_CNT_ONE;
          if (st_ff.wbeat == DBS_BEAT_LAST)
          begin
            nxt_st.mode = DBS_IDLE; // R10
          end
        end
      end
      DBS_READ:
      begin
        if (buf_in_valid && buf_in_ready)
        begin
          nxt_st.fetch = st_ff.fetch + DBS_CNT_ONE;
        end
        if (buf_out_ready && buf_out_valid)
        begin
          nxt_st.launch = st_ff.launch + DBS_CNT_ONE;
          if (st_ff.launch == DBS_BEAT_LAST)
          begin
            nxt_st.mode = DBS_IDLE; // R10
          end
        end
      end
      default:
      begin
        nxt_st.mode = DBS_IDLE;
      end
    endcase
    // output drive: on while a read word is launched, released on the next true edge
    if (buf_out_ready && buf_out_valid)
    begin
      nxt_st.dq = buf_out_data;
      nxt_st.oe = 1'b1;
    end
    else if (launch_pos)
    begin
      nxt_st.oe = 1'b0; // R11
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_ff <= '0; // R07
    end
    else
    begin
      st_ff <= nxt_st; // R12
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset_n && wr_take)
    begin
      mem[wr_addr] <= dq_in; // R01 R04
    end
  end

  assign dq_out = st_ff.dq;
  assign dq_oe = st_ff.oe;
  assign echo_strobe_pos = st_ff.echo_p;
  assign echo_strobe_neg = st_ff.echo_n;
  assign busy = (st_ff.mode != DBS_IDLE);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_reset_hiz: assert property ($past(reset_n) == 1'b0 |-> !dq_oe) // R07
    else $error("data pins driven right after reset");
  a_write_start: assert property (cmd_take && !cmd.rw_sel |=> st_ff.mode == DBS_WRITE) // R01
    else $error("write burst did not start");
  a_read_start: assert property (cmd_take && cmd.rw_sel |=> st_ff.mode == DBS_READ) // R02
    else $error("read burst did not start");
  a_cmd_k_only: assert property (st_ff.mode == DBS_IDLE && !edges.k_rise |=> !busy) // R03
    else $error("command taken without a true input edge");
  a_wr_dual_edge: assert property (wr_take |-> (edges.k_rise || edges.kn_rise)) // R04
    else $error("write word taken off an input edge");
  a_launch_src: assert property (buf_out_ready |-> // R05
    (out_clks_high ? (edges.k_rise || edges.kn_rise) : (edges.c_rise || edges.cn_rise)))
    else $error("read word launched on the wrong clock");
  a_first_addr: assert property (cmd_take |=> st_ff.base == $past(cmd.addr)) // R06
    else $error("burst base is not the external address");
  a_wrap_order: assert property (wr_take && st_ff.wbeat == DBS_BEAT_LAST |-> // R09
    wr_addr[1:0] == 2'(st_ff.base[1:0] - 2'h1) && wr_addr[DBS_ADDR_W-1:2] ==
    st_ff.base[DBS_ADDR_W-1:2])
    else $error("last burst address out of linear order");
  a_burst_four: assert property (st_ff.mode == DBS_READ && buf_out_ready && buf_out_valid && // R10
    st_ff.launch == DBS_BEAT_LAST |=> !busy && dq_oe)
    else $error("read burst did not end after four words");
  a_nop_quiet: assert property (edges.k_rise && cmd.load_strobe_n && !busy && !dq_oe |=> // R11
    !busy && !dq_oe)
    else $error("no-operation changed the bus");
  a_clock_stop: assert property (edges == '0 && st_ff.mode != DBS_READ |=> // R12
    $stable(st_ff.mode) && $stable(st_ff.wbeat) && $stable(dq_oe))
    else $error("state moved while clocks were stopped");

  c_write_burst: cover property (st_ff.mode == DBS_WRITE && wr_take && st_ff.wbeat == DBS_BEAT_LAST);
  c_read_burst: cover property (buf_out_ready && st_ff.launch == DBS_BEAT_LAST);
  c_fallback: cover property (out_clks_high && buf_out_ready && buf_out_valid);
  c_read_stall: cover property (buf_in_valid && !buf_in_ready);
endmodule
`default_nettype wire

// ### verif/dbs_host_clk.sv
// partner: host side clock pairs, one rising-edge strobe of each pair per core_clk cycle unless c_held stops the output pair, true and complement alternating
// assumes the bench stops and restarts the clocks through run
`timescale 1ns/1ps
`default_nettype none
module dbs_host_clk (
  input wire logic core_clk,
  input wire logic run,
  input wire logic c_held,
  output wire dbs_pkg::dbs_edges_t edges
);
  import dbs_pkg::*;
  logic phase_ff = 1'b1;
  // stopped clocks park: no strobes, phase kept for restart
  // output clocks held high give no output-clock strobes
  assign edges = run ? {phase_ff, ~phase_ff, phase_ff & ~c_held, ~phase_ff & ~c_held} :
    '0;
  always_ff @(posedge core_clk)
  begin
    if (run)
      phase_ff <= ~phase_ff;
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the ddr burst sram bus-cycle block
// assumes dbs_host_clk supplies the clock strobes
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbs_pkg::*;
  typedef struct packed {logic [1:0] wr_lo; logic [1:0] rd_lo; logic out_hi; logic stall;} dbs_row_t;
  localparam dbs_row_t ROWS [4] = '{'{2'h0, 2'h0, 1'b0, 1'b0}, '{2'h1, 2'h3, 1'b1, 1'b1},
    '{2'h2, 2'h1, 1'b0, 1'b0}, '{2'h3, 2'h2, 1'b1, 1'b0}};
  logic core_clk = 1'b0;
  logic reset_n;
  logic run;
  logic out_clks_high;
  dbs_cmd_t cmd;
  logic [DBS_DATA_W-1:0] dq_in;
  logic [DBS_DATA_W-1:0] dq_out;
  logic dq_oe;
  logic echo_strobe_pos;
  logic echo_strobe_neg;
  logic busy;
  dbs_edges_t edges;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [DBS_DATA_W-1:0] exp [4];
  logic [DBS_ADDR_W-3:0] up;
  logic [DBS_DATA_W-1:0] d;
  logic [1:0] k;

  dbs_host_clk i_host (.core_clk(core_clk), .run(run), .c_held(out_clks_high), .edges(edges));
  dbs_bus_cycle i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .edges(edges), .out_clks_high(out_clks_high),
    .cmd(cmd), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe_pos(echo_strobe_pos),
    .echo_strobe_neg(echo_strobe_neg), .busy(busy)
  );

  always #50 core_clk = ~core_clk;

  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk_flag(input logic got, input logic want);
    n_checks++;
    if (got !== want)
    begin
      fails++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, want);
    end
  endtask

  task automatic chk_word(input logic [DBS_DATA_W-1:0] got, input logic [DBS_DATA_W-1:0] want);
    n_checks++;
    if (got !== want)
    begin
      fails++;
      $display("mismatch at %0t: word %h expected %h", $time, got, want);
    end
  endtask

  // load held until a true input edge finds the block idle
  task automatic send_cmd(input logic rw, input logic [DBS_ADDR_W-1:0] a);
    cmd <= '{1'b0, rw, a};
    do @(posedge core_clk); while (!(edges.k_rise === 1'b1 && busy === 1'b0));
    cmd <= '{1'b1, 1'b0, ~a};
  endtask

  task automatic wr_burst(input logic [DBS_ADDR_W-1:0] a, input logic stall);
    int b;
    b = 0;
    send_cmd(1'b0, a);
    dq_in <= d;
    while (b < 4)
    begin
      @(posedge core_clk);
      if ((b[0] ? edges.kn_rise : edges.k_rise) === 1'b1)
      begin
        b++;
        dq_in <= d + 36'(b);
        if (stall && b == 2)
        begin
          run <= 1'b0;
          repeat (3) @(posedge core_clk);
          chk_flag(busy, 1'b1);
          run <= 1'b1;
        end
      end
    end
  endtask

  task automatic rd_burst(input logic [DBS_ADDR_W-1:0] a, input logic stall);
    int n;
    int t;
    n = 0;
    t = 0;
    send_cmd(1'b1, a);
    while (n < 4 && t < 30)
    begin
      @(posedge core_clk);
      t++;
      if (dq_oe === 1'b1 && (echo_strobe_pos | echo_strobe_neg) === 1'b1)
      begin
        chk_flag(echo_strobe_pos, ~n[0]);
        chk_flag(echo_strobe_neg, n[0]);
        chk_word(dq_out, exp[n]);
        n++;
      end
      // clocks stopped before the first launch: prefetch fills the buffer
      if (stall && t == 1)
        run <= 1'b0;
      if (stall && t == 4)
      begin
        chk_flag(busy, 1'b1);
        run <= 1'b1;
      end
    end
    chk_flag(n == 4, 1'b1);
    repeat (3) @(posedge core_clk);
    chk_flag(dq_oe, 1'b0);
    chk_flag(busy, 1'b0);
  endtask

  initial
  begin
    reset_n = 1'b0;
    run = 1'b0;
    out_clks_high = 1'b0;
    cmd = '{1'b1, 1'b0, '0};
    dq_in = '0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    chk_flag(dq_oe, 1'b0);
    run <= 1'b1;
    do @(posedge core_clk); while (edges.k_rise !== 1'b1);
    // load shown only at a complement edge
    cmd <= '{1'b0, 1'b0, '0};
    @(posedge core_clk);
    cmd <= '{1'b1, 1'b0, '0};
    repeat (4) @(posedge core_clk);
    chk_flag(busy, 1'b0);
    chk_flag(dq_oe, 1'b0);
    foreach (ROWS[r])
    begin
      up = 16'(r * 37 + 5);
      d = 36'ha5c30f000 + 36'(r * 16);
      out_clks_high <= ROWS[r].out_hi;
      wr_burst({up, ROWS[r].wr_lo}, ROWS[r].stall);
      for (int i = 0; i < 4; i++)
      begin
        k = ROWS[r].rd_lo + 2'(i) - ROWS[r].wr_lo;
        exp[i] = d + 36'(k);
      end
      rd_burst({up, ROWS[r].rd_lo}, ROWS[r].stall);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
